// >>> inc/lin_sync_params.svh
/*
  Constants for the LIN slave header synchroniser: field positions,
  reset values and timing figures.
  Assumes a 25 MHz core clock; included by bare name.
*/
`ifndef LIN_SYNC_PARAMS_SVH
`define LIN_SYNC_PARAMS_SVH
`define CLK_HZ          25000000
`define LPOSC_HZ        131000
`define SYNC_HZ         5000000
`define BRK_CMP_RST     12'h047
`define EDGE_CFG_RST    8'h32
`define STOP_MSB        7
`define STOP_LSB        4
`define START_MSB       3
`define START_LSB       0
`define RESET_TIME_US   15
`define RESET_CYC       ((`RESET_TIME_US * `CLK_HZ) / 1000000)
`define LP_DIV          (`CLK_HZ / `LPOSC_HZ)
`define SYNC_DIV        (`CLK_HZ / `SYNC_HZ)
`define RST_DONE_BIT    5
`define FLG_BRK         0
`define FLG_STOP        1
`define FLG_BERR        4
`define FLG_FAULT       6
`endif

// >>> inc/lin_sync_pkg.sv
/*
  Types for the LIN slave header synchroniser.
  Assumes lin_sync_params.svh is compiled alongside.
*/
package lin_sync_pkg;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_BREAK = 5'h02,
    ST_WAIT  = 5'h04,
    ST_SYNC  = 5'h08,
    ST_DONE  = 5'h10
  } hdr_state_t;

  typedef struct packed {
    logic       enable;
    logic       clearEdges;
    logic       stopIrqEn;
    logic       breakIrqEn;
    logic       gateRx;
  } sync_ctrl_t;
endpackage

// >>> rtl/lin_slave_header_sync.sv
/*
  LIN slave header front end: break timing and compare, sync byte
  timing by falling-edge count, UART gating, pin readback and drive,
  short flag. Assumes linIn already synchronous to clk; the UART and
  divisor registers sit outside and take the sync timer value.
*/
`timescale 1ns/100ps
`include "lin_sync_params.svh"

module lin_slave_header_sync (
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire logic                     linIn,
  input  wire logic                     linShort,
  input  wire lin_sync_pkg::sync_ctrl_t syncCtrl,
  input  wire logic                     syncReset,
  input  wire logic                     edgeCfgWr,
  input  wire logic [7:0]               edgeCfgData,
  input  wire logic                     breakCmpWr,
  input  wire logic [11:0]              breakCmpData,
  input  wire logic                     breakTimerRd,
  input  wire logic                     flagsRd,
  input  wire logic                     port1UartSel,
  input  wire logic                     port2GpioSel,
  input  wire logic                     port2DriveVal,
  input  wire logic                     driverEnable,
  input  wire logic                     shortProtDis,
  input  wire logic                     uartTxd,
  input  wire logic                     uartTxdIn,
  output logic                          linOut,
  output logic                          linOe,
  output logic                          uartRxd,
  output logic                          gpioTxd,
  output logic                          gpioRxdOut,
  output logic [15:0]                   syncTimer,
  output logic [11:0]                   breakTimer,
  output logic [7:0]                    edgeCfg,
  output logic [7:0]                    syncFlags,
  output logic                          syncIrq,
  output logic                          linLevel,
  output logic                          shortFlag,
  output logic                          headerDone
);
  lin_sync_pkg::hdr_state_t state_r;
  lin_sync_pkg::hdr_state_t state_nxt;
  logic        linPrev_r;
  logic [11:0] brkCmp_r;
  logic [7:0]  lpDiv_r;
  logic [2:0]  syDiv_r;
  logic [3:0]  edges_r;
  logic [9:0]  rstCnt_r;
  logic        rstBusy_r;
  logic        brkHit_r;
  logic        gateHold_r;
  logic        driverEnPrev_r;

  // Event decode and tick generation
  wire fallEdge  = linPrev_r & ~linIn;
  wire riseEdge  = ~linPrev_r & linIn;
  wire lpTick    = (lpDiv_r == 8'(`LP_DIV - 1));
  wire syTick    = (syDiv_r == 3'(`SYNC_DIV - 1));
  wire active    = syncCtrl.enable & ~rstBusy_r;
  wire edgeClr   = syncCtrl.clearEdges | rstBusy_r;
  wire [3:0] stopEdge  = edgeCfg[`STOP_MSB:`STOP_LSB];
  wire [3:0] startEdge = edgeCfg[`START_MSB:`START_LSB];
  wire [3:0] edgesNext = edges_r + 4'h1;
  // Break edge is edge one; timer runs from start edge to stop edge
  wire syncStart = fallEdge & (edgesNext == startEdge);
  wire stopHit   = fallEdge & (edgesNext == stopEdge);
  wire brkCmpHit = lpTick & (breakTimer == brkCmp_r)
                   & (state_r == lin_sync_pkg::ST_BREAK);
  wire brkOvf    = lpTick & (breakTimer == 12'hfff)
                   & ~linIn;
  wire ev_brk    = brkCmpHit & ~brkHit_r;
  wire ev_stop   = active & stopHit
                   & (state_r == lin_sync_pkg::ST_SYNC);
  wire ev_berr   = active & brkOvf;
  wire short_set = linShort & ~shortProtDis;
  wire drvRise   = driverEnable & ~driverEnPrev_r;

  // Header sequencer; a break restarts the frame only from ST_IDLE or ST_DONE
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      lin_sync_pkg::ST_IDLE:  if (active & fallEdge)
                                state_nxt = lin_sync_pkg::ST_BREAK;
      lin_sync_pkg::ST_BREAK: if (riseEdge)
                                state_nxt = brkHit_r ?
                                  lin_sync_pkg::ST_WAIT :
                                  lin_sync_pkg::ST_IDLE;
      lin_sync_pkg::ST_WAIT:  if (syncStart)
                                state_nxt = lin_sync_pkg::ST_SYNC;
      lin_sync_pkg::ST_SYNC:  if (stopHit)
                                state_nxt = lin_sync_pkg::ST_DONE;
      lin_sync_pkg::ST_DONE:  if (fallEdge)
                                state_nxt = lin_sync_pkg::ST_BREAK;
      default:                state_nxt = lin_sync_pkg::ST_IDLE;
    endcase
    if (!active)
      state_nxt = lin_sync_pkg::ST_IDLE;
  end

  // Sequencer state, pin history, prescalers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r        <= lin_sync_pkg::ST_IDLE;
      linPrev_r      <= 1'b1;
      lpDiv_r        <= 8'h00;
      syDiv_r        <= 3'h0;
      driverEnPrev_r <= 1'b0;
    end else begin
      state_r        <= state_nxt;
      linPrev_r      <= linIn;
      lpDiv_r        <= lpTick ? 8'h00 : lpDiv_r + 8'h01;
      syDiv_r        <= syTick ? 3'h0 : syDiv_r + 3'h1;
      driverEnPrev_r <= driverEnable;
    end
  end

  // Break timer: cleared by any falling edge or by a read
  always_ff @(posedge clk) begin
    if (!reset_n || rstBusy_r) begin
      breakTimer <= 12'h000;
      brkHit_r   <= 1'b0;
    end else begin
      if (fallEdge | breakTimerRd)
        breakTimer <= 12'h000;
      else if (lpTick & ~linIn & (breakTimer != 12'hfff))
        breakTimer <= breakTimer + 12'h001;
      if (fallEdge & (state_r != lin_sync_pkg::ST_BREAK))
        brkHit_r <= 1'b0;
      else if (brkCmpHit)
        brkHit_r <= 1'b1;
    end
  end

  // Compare and edge configuration, reset values per header
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      brkCmp_r <= `BRK_CMP_RST;
      edgeCfg  <= `EDGE_CFG_RST;
    end else begin
      if (breakCmpWr)
        brkCmp_r <= breakCmpData;
      if (edgeCfgWr)
        edgeCfg <= edgeCfgData;
    end
  end

  // Edge counter and sync timer; timer freezes at the stop edge
  always_ff @(posedge clk) begin
    if (!reset_n || edgeClr) begin
      edges_r   <= 4'h0;
      syncTimer <= 16'h0000;
    end else begin
      if (fallEdge && state_r == lin_sync_pkg::ST_IDLE && active)
        edges_r <= 4'h1;
      else if (fallEdge && state_r != lin_sync_pkg::ST_DONE)
        edges_r <= edgesNext;
      if (fallEdge && state_r == lin_sync_pkg::ST_DONE)
        edges_r <= 4'h1;
      if (syncStart && state_r == lin_sync_pkg::ST_WAIT)
        syncTimer <= 16'h0000;
      else if (syTick && state_r == lin_sync_pkg::ST_SYNC)
        syncTimer <= syncTimer + 16'h0001;
    end
  end

  // Soft reset of the sync logic; busy for about 15 us
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rstCnt_r  <= 10'h000;
      rstBusy_r <= 1'b0;
    end else if (syncReset) begin
      rstCnt_r  <= 10'(`RESET_CYC);
      rstBusy_r <= 1'b1;
    end else if (rstCnt_r != 10'h000) begin
      rstCnt_r <= rstCnt_r - 10'h001;
    end else begin
      rstBusy_r <= 1'b0;
    end
  end

  // Sticky break, stop and error flags, live fault and reset-done bits; a same-cycle event beats the read clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      syncFlags <= 8'h00;
      syncIrq   <= 1'b0;
    end else begin
      if (flagsRd)
        syncFlags <= 8'h00;
      if (ev_brk)
        syncFlags[`FLG_BRK] <= 1'b1;
      if (ev_stop)
        syncFlags[`FLG_STOP] <= 1'b1;
      if (ev_berr)
        syncFlags[`FLG_BERR] <= 1'b1;
      syncFlags[`FLG_FAULT] <= ~linIn & (breakTimer == 12'hfff);
      syncFlags[`RST_DONE_BIT] <= ~rstBusy_r & ~syncReset;
      syncIrq <= (ev_brk & syncCtrl.breakIrqEn)
                 | (ev_stop & syncCtrl.stopIrqEn) | ev_berr
                 | (syncIrq & ~flagsRd);
    end
  end

  // Receive gate holds until the bus is high after the stop edge
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      gateHold_r <= 1'b1;
      headerDone <= 1'b0;
      uartRxd    <= 1'b1;
    end else begin
      if (state_r != lin_sync_pkg::ST_DONE)
        gateHold_r <= 1'b1;
      else if (linIn)
        gateHold_r <= 1'b0;
      headerDone <= (state_r == lin_sync_pkg::ST_DONE)
                    & ~gateHold_r;
      // Identifier and data bytes reach the UART only through this path
      uartRxd <= (syncCtrl.gateRx & gateHold_r) ? 1'b1 :
                 (port1UartSel ? uartTxdIn : linIn);
    end
  end

  // Pin drive, routing, readback and short flag
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      linOut     <= 1'b1;
      linOe      <= 1'b0;
      gpioTxd    <= 1'b1;
      gpioRxdOut <= 1'b1;
      linLevel   <= 1'b1;
      shortFlag  <= 1'b0;
    end else begin
      linOut  <= port2GpioSel ? port2DriveVal : uartTxd;
      linOe   <= driverEnable & ~shortFlag
                 & (port2GpioSel | ~port1UartSel);
      gpioTxd <= port1UartSel ? uartTxd : 1'b1;
      gpioRxdOut <= port1UartSel ? linIn : 1'b1;
      linLevel   <= linIn;
      if (short_set)
        shortFlag <= 1'b1;
      else if (drvRise)
        shortFlag <= 1'b0;
    end
  end
endmodule // lin_slave_header_sync

// >>> testbench/lin_master_model.sv
/*
  Behavioural LIN master: break, delimiter, sync byte, protected
  identifier and one data byte. Assumes the bench wires the bus.
*/
`timescale 1ns/100ps
module lin_master_model #(
  parameter int BIT = 100
) (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [15:0] brkLen,
  input  wire logic [7:0]  id,
  output logic             linBus,
  output logic             busy
);
  // Released bus sits at the recessive pull-up level
  initial begin
    linBus = 1'b1;
    busy = 1'b0;
  end
  // Hold one level for a number of clocks
  task automatic hold(input logic v, input int n);
    linBus <= v;
    repeat (n) @(posedge clk);
  endtask
  // Start bit, eight bits LSB first, stop bit
  task automatic sendByte(input logic [7:0] b);
    hold(1'b0, BIT);
    for (int i = 0; i < 8; i++) hold(b[i], BIT);
    hold(1'b1, BIT);
  endtask
  // One whole frame per request; requests mid-frame go unseen while this block runs, busy only marks the frame
  always @(posedge clk) if (go) begin
    busy <= 1'b1;
    hold(1'b0, brkLen);
    hold(1'b1, BIT);
    sendByte(8'h55);
    sendByte({~(id[1] ^ id[3] ^ id[4] ^ id[5]),
              id[0] ^ id[1] ^ id[2] ^ id[4], id[5:0]});
    sendByte(8'ha5);
    busy <= 1'b0;
  end
endmodule // lin_master_model

// >>> testbench/lin_slave_header_sync_bench.sv
/*
  Self-checking bench for lin_slave_header_sync with a LIN master.
  Assumes the model and checker are compiled before it.
*/
`timescale 1ns/100ps
`include "lin_sync_params.svh"
module lin_slave_header_sync_bench;
  logic clk = 1'b0, reset_n = 1'b0, linShort = 1'b0, syncReset = 1'b0;
  logic edgeCfgWr = 1'b0, breakCmpWr = 1'b0, flagsRd = 1'b0, go = 1'b0;
  logic port1UartSel = 1'b0, port2GpioSel = 1'b0, port2DriveVal = 1'b0;
  logic driverEnable = 1'b1, shortProtDis = 1'b0, uartTxd = 1'b1;
  logic uartTxdIn = 1'b1, linOut, linOe, uartRxd, gpioTxd, gpioRxdOut;
  logic syncIrq, linLevel, shortFlag, headerDone, mBus, mBusy, linIn;
  logic breakTimerRd = 1'b0, sawDone = 1'b0;
  logic [7:0] edgeCfgData = 8'h00, edgeCfg, syncFlags, rnd = 8'h3f;
  logic [7:0] pid = 8'h09;
  logic [11:0] breakCmpData = 12'h000, breakTimer;
  logic [15:0] syncTimer, brkLen = 16'h0000;
  lin_sync_pkg::sync_ctrl_t syncCtrl = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  int bad_count = 0, comparisons = 0, n;
  int lens[2] = '{32'h41, 32'h4b}; // Break ticks around the 0x47 default
  always #20 clk = ~clk;
  // Wired bus: a dominant low from either party wins
  assign linIn = mBus & (linOe ? linOut : 1'b1);
  lin_slave_header_sync DUT (.clk, .reset_n, .linIn, .linShort, .syncCtrl,
    .syncReset, .edgeCfgWr, .edgeCfgData, .breakCmpWr, .breakCmpData,
    .breakTimerRd, .flagsRd, .port1UartSel, .port2GpioSel, .port2DriveVal,
    .driverEnable, .shortProtDis, .uartTxd, .uartTxdIn, .linOut, .linOe,
    .uartRxd, .gpioTxd, .gpioRxdOut, .syncTimer, .breakTimer, .edgeCfg,
    .syncFlags, .syncIrq, .linLevel, .shortFlag, .headerDone);
  lin_master_model master (.clk, .go, .brkLen, .id(pid), .linBus(mBus),
    .busy(mBusy));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Identifier bits 0 and 3 kept high so no data low run reaches a break
  task automatic frame(input logic [15:0] len);
    pid <= rnd | 8'h09;
    brkLen <= len;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    n = 0;
    sawDone = 1'b0;
    // headerDone only stands until the next falling edge, so watch it live
    do begin
      @(posedge clk);
      n++;
      if (headerDone === 1'b1) sawDone = 1'b1;
    end while ((mBusy !== 1'b0 || n < 3) && n < 60000);
    if (n >= 60000) begin
      bad_count++;
      summarize();
    end
    rnd = lfsr(rnd);
    repeat (20) @(posedge clk);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(edgeCfg, 32'h32);
    syncReset <= 1'b1;
    @(posedge clk);
    syncReset <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (syncFlags[5] !== 1'b1 && n < 1000);
    chk(n > `RESET_CYC - 5 && n < `RESET_CYC + 10, 32'h1);
    // Default compare: a short break is ignored, a long one starts a header
    foreach (lens[i]) begin
      frame(16'(lens[i] * `LP_DIV));
      chk({syncFlags[1:0], syncIrq}, i ? 32'h7 : 32'h0);
      if (i) chk(syncTimer > 16'h26 && syncTimer < 16'h2a, 32'h1);
      chk(sawDone, 32'(i));
      flagsRd <= 1'b1;
      @(posedge clk);
      flagsRd <= 1'b0;
      repeat (2) @(posedge clk);
      chk({syncFlags[1:0], syncIrq}, 32'h0);
    end
    edgeCfgData <= 8'h62;
    edgeCfgWr <= 1'b1;
    breakCmpData <= 12'h004;
    breakCmpWr <= 1'b1;
    @(posedge clk);
    edgeCfgWr <= 1'b0;
    breakCmpWr <= 1'b0;
    @(posedge clk);
    chk(edgeCfg, 32'h62);
    frame(16'h0514);
    chk(syncFlags[1:0], 32'h3);
    chk(syncTimer > 16'h9d && syncTimer < 16'ha3, 32'h1);
    // Software view: rounded eighth of the timer is one bit in 5 MHz ticks
    chk(32'((syncTimer + 16'h0004) >> 3), 32'h14);
    // Random pin traffic for routing, readback, drive and short paths
    for (int k = 0; k < 40; k++) begin
      rnd = lfsr(rnd);
      {uartTxdIn, shortProtDis, port2DriveVal, port2GpioSel} <= rnd[7:4];
      {uartTxd, port1UartSel} <= rnd[1:0];
      linShort <= rnd[2] & rnd[3];
      repeat (4) @(posedge clk);
      if (port1UartSel) chk(gpioTxd, uartTxd);
      chk(linLevel, linIn);
      if (port2GpioSel && !shortFlag && !linShort)
        chk(linOut, port2DriveVal);
      if (linShort && !shortProtDis) chk(shortFlag, 32'h1);
    end
    linShort <= 1'b0;
    driverEnable <= 1'b0;
    @(posedge clk);
    driverEnable <= 1'b1;
    repeat (4) @(posedge clk);
    chk(shortFlag, 32'h0);
    summarize();
  end
endmodule // lin_slave_header_sync_bench

// >>> testbench/lin_sync_checker.sv
/*
  Port assertions for the header synchroniser.
  Assumes it is bound into lin_slave_header_sync.
*/
`timescale 1ns/100ps
module lin_sync_checker (
  input wire logic                     clk,
  input wire logic                     reset_n,
  input wire logic                     linIn,
  input wire logic                     linShort,
  input wire lin_sync_pkg::sync_ctrl_t syncCtrl,
  input wire logic                     syncReset,
  input wire logic                     flagsRd,
  input wire logic                     port1UartSel,
  input wire logic                     port2GpioSel,
  input wire logic                     port2DriveVal,
  input wire logic                     driverEnable,
  input wire logic                     shortProtDis,
  input wire logic                     uartTxd,
  input wire logic                     linOut,
  input wire logic                     uartRxd,
  input wire logic                     gpioTxd,
  input wire logic [15:0]              syncTimer,
  input wire logic [7:0]               syncFlags,
  input wire logic                     syncIrq,
  input wire logic                     linLevel,
  input wire logic                     shortFlag,
  input wire logic                     headerDone
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Pin paths, compared only once their causes have settled
  property p_level;
    (reset_n && $stable(linIn))[*4] |-> linLevel == linIn;
  endproperty
  a_level: assert property (p_level)
    else $error("bus readback wrong");
  property p_drive;
    (reset_n && port2GpioSel && driverEnable && !linShort && !shortFlag
     && $stable(port2DriveVal))[*3] |-> linOut == port2DriveVal;
  endproperty
  a_drive: assert property (p_drive)
    else $error("pin drive wrong");
  property p_route;
    (reset_n && port1UartSel && $stable(uartTxd))[*3] |-> gpioTxd == uartTxd;
  endproperty
  a_route: assert property (p_route)
    else $error("transmit route wrong");
  // Receive stays idle while gated and the header is still open
  property p_gate;
    (reset_n && syncCtrl.gateRx && !headerDone)[*2] |-> uartRxd;
  endproperty
  a_gate: assert property (p_gate)
    else $error("gated receive moved");
  property p_short;
    linShort && !shortProtDis |-> ##[1:3] shortFlag;
  endproperty
  a_short: assert property (p_short)
    else $error("short not flagged");
  // Header events, flag clearing and sync reset; a bus high for two
  // cycles means no break or stop event can land with the read
  property p_clr;
    flagsRd && linIn && $past(linIn) |=> syncFlags[1:0] == 2'h0;
  endproperty
  a_clr: assert property (p_clr)
    else $error("flags not cleared");
  property p_irq;
    $rose(syncFlags[1]) && syncCtrl.stopIrqEn |-> ##[0:1] syncIrq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("stop irq missing");
  property p_freeze;
    $rose(syncFlags[1]) |=> $stable(syncTimer)[*4];
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("sync timer ran on");
  property p_rst;
    syncReset |=> !syncFlags[5] ##1 !syncFlags[5];
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset done too early");
endmodule // lin_sync_checker
bind lin_slave_header_sync lin_sync_checker chk_i (.clk, .reset_n, .linIn,
  .linShort, .syncCtrl, .syncReset, .flagsRd, .port1UartSel, .port2GpioSel,
  .port2DriveVal, .driverEnable, .shortProtDis, .uartTxd, .linOut, .uartRxd,
  .gpioTxd, .syncTimer, .syncFlags, .syncIrq, .linLevel, .shortFlag,
  .headerDone);
